/* rtl/lpd_pkg.sv */
// constants shared by the led pulse dimming and pump mode controller
package lpd_pkg;

    // ----------------------------------------
    // clock and timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam real SHDN_DELAY_MS = 0.5;
    localparam real SOFT_START_MS = 2.0;
    localparam real GAIN_DWELL_MS = 1.0;
    localparam real GAIN_RETRY_MS = 130.0;
    // typical figures, rounded down to whole cycles
    localparam int SHDN_CYC = int'($floor(SHDN_DELAY_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int SS_CYC = int'($floor(SOFT_START_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int DWELL_CYC = int'($floor(GAIN_DWELL_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int RETRY_CYC = int'($floor(GAIN_RETRY_MS * 1.0e6 / CLK_PERIOD_NS));

    // ----------------------------------------
    // dimming levels
    // ----------------------------------------
    localparam logic [3:0] LVL_MAX = 4'ha;
    localparam logic [6:0] LVL_FULL = 7'h64;
    localparam logic [6:0] LVL_STEP = 7'h0a;
    localparam logic [6:0] LVL_LOWEST = 7'h05;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] STAT_OFF = 12'h004;
    localparam logic [11:0] LVL_OFF = 12'h008;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam int CTRL_EN_BIT = 0;
    localparam int STAT_BL_IDX_LSB = 0;
    localparam int STAT_FL_IDX_LSB = 4;
    localparam int STAT_GAIN_LSB = 8;
    localparam int STAT_SS_DONE_BIT = 12;
    localparam int STAT_SHUT_BIT = 13;
    localparam int STAT_SHORT_BIT = 14;
    localparam int STAT_HOT_BIT = 15;
    localparam int STAT_BL_ON_BIT = 16;
    localparam int STAT_FL_ON_BIT = 17;
    localparam int STAT_LED_LSB = 24;
    localparam int LVL_BL_LSB = 0;
    localparam int LVL_FL_LSB = 8;

    // ----------------------------------------
    // pump gain states
    // ----------------------------------------
    typedef enum logic [2:0] {
        GAIN_1X = 3'b001,
        GAIN_15X = 3'b010,
        GAIN_2X = 3'b100
    } lpd_gain_t;

endpackage

/* rtl/lpd_ctrl.sv */
// pulse dimming, shutdown detect, soft-start, pump gain sequencer, apb registers
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps

module lpd_ctrl
    import lpd_pkg::*;
#(
    parameter int SHDN_CYCLES = SHDN_CYC,
    parameter int SS_CYCLES = SS_CYC,
    parameter int DWELL_CYCLES = DWELL_CYC,
    parameter int RETRY_CYCLES = RETRY_CYC
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic backlight_pulse_in,
    input wire logic flash_pulse_in,
    input wire logic [5:0] headroom_low,
    input wire logic [5:0] led_pin_high,
    input wire logic dropout_det,
    input wire logic pump_output_voltage_le_vin,
    input wire logic pump_output_voltage_short,
    input wire logic over_temp,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [5:0] led_enable,
    output logic [6:0] backlight_percent,
    output logic [6:0] flash_current_ma,
    output logic [2:0] pump_gain,
    output logic pump_enable,
    output logic soft_start_active,
    output logic shutdown
);

    // ----------------------------------------
    // reset release and input synchronisers
    // ----------------------------------------
    logic rst_meta_reg;
    logic rst_n;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // analog comparators and pins are all asynchronous here
    logic [17:0] async_in;
    logic [17:0] sync1_reg;
    logic [17:0] sync2_reg;

    assign async_in = {over_temp, pump_output_voltage_short, pump_output_voltage_le_vin, dropout_det,
                       led_pin_high, headroom_low, flash_pulse_in, backlight_pulse_in};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 18'h00000;
            sync2_reg <= 18'h00000;
        end else begin
            sync1_reg <= async_in;
            sync2_reg <= sync1_reg;
        end
    end

    logic [1:0] pin_s;
    logic [5:0] head_s;
    logic [5:0] over_s;
    logic drop_s;
    logic le_s;
    logic short_s;
    logic hot_s;

    assign pin_s = sync2_reg[1:0];
    assign head_s = sync2_reg[7:2];
    assign over_s = sync2_reg[13:8];
    assign drop_s = sync2_reg[14];
    assign le_s = sync2_reg[15];
    assign short_s = sync2_reg[16];
    assign hot_s = sync2_reg[17];

    // ----------------------------------------
    // pulse decoders, channel 0 backlight, 1 flash
    // ----------------------------------------
    logic [1:0] pin_d_reg;
    logic [1:0] armed_reg;
    logic [1:0] low_long;
    logic [1:0] ch_on;
    logic [3:0] idx_reg [2];
    logic [6:0] level [2];
    logic [19:0] low_cnt_reg [2];

    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_ch
            assign low_long[c] = (low_cnt_reg[c] == 20'(SHDN_CYCLES));
            assign ch_on[c] = armed_reg[c] & ~low_long[c];

            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    pin_d_reg[c] <= 1'b0;
                end else begin
                    pin_d_reg[c] <= pin_s[c];
                end
            end

            // saturating low-time counter
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    low_cnt_reg[c] <= 20'h00000;
                end else if (pin_s[c]) begin
                    low_cnt_reg[c] <= 20'h00000;
                end else if (!low_long[c]) begin
                    low_cnt_reg[c] <= low_cnt_reg[c] + 20'h00001;
                end
            end

            // every rise counts: no 1 ms window is enforced, so late pulses still dim
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    armed_reg[c] <= 1'b0;
                    idx_reg[c] <= 4'h0;
                end else if (pin_s[c] && !pin_d_reg[c]) begin
                    if (!armed_reg[c] || low_long[c]) begin
                        armed_reg[c] <= 1'b1;
                        idx_reg[c] <= 4'h0;
                    end else if (idx_reg[c] == LVL_MAX) begin
                        idx_reg[c] <= 4'h0;
                    end else begin
                        idx_reg[c] <= idx_reg[c] + 4'h1;
                    end
                end
            end

            // ten percent (or 10 mA) steps, last one is a half step
            always_comb begin
                if (idx_reg[c] == LVL_MAX) begin
                    level[c] = LVL_LOWEST;
                end else begin
                    level[c] = 7'(LVL_FULL - 7'(idx_reg[c]) * LVL_STEP);
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // control register field
    // ----------------------------------------
    logic [31:0] ctrl_reg;
    logic ctrl_en;

    assign ctrl_en = ctrl_reg[CTRL_EN_BIT];

    // ----------------------------------------
    // shutdown, protection and soft-start
    // ----------------------------------------
    logic idle_all;
    logic chip_off;
    logic ss_done_reg;
    logic [21:0] ss_cnt_reg;

    assign idle_all = ~ch_on[0] & ~ch_on[1];
    assign chip_off = idle_all | hot_s | ~ctrl_en;

    // soft-start is shared, so a flash start after backlight skips it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ss_cnt_reg <= 22'h000000;
            ss_done_reg <= 1'b0;
        end else if (chip_off) begin
            ss_cnt_reg <= 22'h000000;
            ss_done_reg <= 1'b0;
        end else if (!ss_done_reg) begin
            if (ss_cnt_reg == 22'(SS_CYCLES - 1)) begin
                ss_done_reg <= 1'b1;
            end else begin
                ss_cnt_reg <= ss_cnt_reg + 22'h000001;
            end
        end
    end

    logic pump_run;

    assign pump_run = ~chip_off & ~short_s;

    // ----------------------------------------
    // led channel enables
    // ----------------------------------------
    logic bl_group;
    logic fl_group;
    logic [5:0] group_on;

    assign bl_group = ss_done_reg & ch_on[0] & ~short_s;
    assign fl_group = ss_done_reg & ch_on[1] & ~short_s;
    assign group_on = {fl_group, fl_group, bl_group, bl_group, bl_group, bl_group};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            led_enable <= 6'h00;
        end else begin
            led_enable <= group_on & ~over_s;
        end
    end

    // ----------------------------------------
    // pump gain sequencer
    // ----------------------------------------
    lpd_gain_t gain_reg;
    logic [23:0] retry_cnt_reg;
    logic [23:0] dwell_cnt_reg;
    logic retry_hit;
    logic dwell_done;
    logic need_up;
    logic split_now;
    logic split_d_reg;
    logic split_rise;

    assign need_up = |(head_s & led_enable);
    assign retry_hit = (retry_cnt_reg == 24'(RETRY_CYCLES - 1));
    assign dwell_done = (dwell_cnt_reg == 24'(DWELL_CYCLES));
    // one group released while the other still driven high
    assign split_now = (low_long[0] & pin_s[1]) | (low_long[1] & pin_s[0]);
    assign split_rise = split_now & ~split_d_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            split_d_reg <= 1'b0;
        end else begin
            split_d_reg <= split_now;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gain_reg <= GAIN_1X;
        end else if (!pump_run) begin
            gain_reg <= GAIN_1X;
        end else begin
            unique case (gain_reg)
                GAIN_1X: begin
                    if (need_up) begin
                        gain_reg <= GAIN_15X;
                    end
                end
                GAIN_15X: begin
                    if (le_s && retry_hit) begin
                        gain_reg <= GAIN_1X;
                    end else if (drop_s && dwell_done) begin
                        gain_reg <= GAIN_2X;
                    end
                end
                GAIN_2X: begin
                    if (split_rise || retry_hit) begin
                        gain_reg <= GAIN_15X;
                    end
                end
            endcase
        end
    end

    // minimum stay in 1.5x before any move up
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dwell_cnt_reg <= 24'h000000;
        end else if (!pump_run || gain_reg != GAIN_15X) begin
            dwell_cnt_reg <= 24'h000000;
        end else if (!dwell_done) begin
            dwell_cnt_reg <= dwell_cnt_reg + 24'h000001;
        end
    end

    // retry period; in 1.5x it only runs while output is not above input
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            retry_cnt_reg <= 24'h000000;
        end else if (!pump_run || gain_reg == GAIN_1X) begin
            retry_cnt_reg <= 24'h000000;
        end else if (gain_reg == GAIN_15X && !le_s) begin
            retry_cnt_reg <= 24'h000000;
        end else if (retry_hit || (gain_reg == GAIN_2X && split_rise)) begin
            retry_cnt_reg <= 24'h000000;
        end else begin
            retry_cnt_reg <= retry_cnt_reg + 24'h000001;
        end
    end

    // ----------------------------------------
    // registered status outputs
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            backlight_percent <= 7'h00;
            flash_current_ma <= 7'h00;
            pump_gain <= 3'h1;
            pump_enable <= 1'b0;
            soft_start_active <= 1'b0;
            shutdown <= 1'b1;
        end else begin
            backlight_percent <= bl_group ? level[0] : 7'h00;
            flash_current_ma <= fl_group ? level[1] : 7'h00;
            pump_gain <= gain_reg;
            pump_enable <= pump_run;
            soft_start_active <= ~chip_off & ~ss_done_reg;
            shutdown <= chip_off;
        end
    end

    // ----------------------------------------
    // apb slave, one wait state per access
    // ----------------------------------------
    logic [31:0] stat_word;
    logic [31:0] lvl_word;
    logic addr_ok;
    logic access;

    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[STAT_BL_IDX_LSB +: 4] = idx_reg[0];
        stat_word[STAT_FL_IDX_LSB +: 4] = idx_reg[1];
        stat_word[STAT_GAIN_LSB +: 3] = gain_reg;
        stat_word[STAT_SS_DONE_BIT] = ss_done_reg;
        stat_word[STAT_SHUT_BIT] = chip_off;
        stat_word[STAT_SHORT_BIT] = short_s;
        stat_word[STAT_HOT_BIT] = hot_s;
        stat_word[STAT_BL_ON_BIT] = bl_group;
        stat_word[STAT_FL_ON_BIT] = fl_group;
        stat_word[STAT_LED_LSB +: 6] = led_enable;
        lvl_word = 32'h0000_0000;
        lvl_word[LVL_BL_LSB +: 7] = level[0];
        lvl_word[LVL_FL_LSB +: 7] = level[1];
    end

    assign addr_ok = (paddr == CTRL_OFF) || (paddr == STAT_OFF) || (paddr == LVL_OFF);
    assign access = psel & penable & pready;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= ~addr_ok;
            if (pwrite || !addr_ok) begin
                prdata <= 32'h0000_0000;
            end else if (paddr == CTRL_OFF) begin
                prdata <= ctrl_reg;
            end else if (paddr == STAT_OFF) begin
                prdata <= stat_word;
            end else begin
                prdata <= lvl_word;
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // only the enable bit is writable
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RST;
        end else if (access && pwrite && paddr == CTRL_OFF) begin
            ctrl_reg[CTRL_EN_BIT] <= pwdata[CTRL_EN_BIT];
        end
    end

endmodule

/* tb/lpd_ctrl_sva.sv */
// concurrent checks on the pulse dimming and pump mode controller ports
`timescale 1ns/1ps
module lpd_ctrl_chk
    import lpd_pkg::*;
#(
    parameter int SHDN_CYCLES = SHDN_CYC,
    parameter int SS_CYCLES = SS_CYC,
    parameter int DWELL_CYCLES = DWELL_CYC
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic backlight_pulse_in,
    input wire logic flash_pulse_in,
    input wire logic [5:0] headroom_low,
    input wire logic [5:0] led_pin_high,
    input wire logic pump_output_voltage_short,
    input wire logic over_temp,
    input wire logic [5:0] led_enable,
    input wire logic [6:0] backlight_percent,
    input wire logic [6:0] flash_current_ma,
    input wire logic [2:0] pump_gain,
    input wire logic pump_enable,
    input wire logic soft_start_active,
    input wire logic shutdown
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // ----------------------------------------
    // helper counters
    // ----------------------------------------
    int ss_cnt;
    int low_cnt;
    int cnt15;
    int bl_low_cnt;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ss_cnt <= 0;
            low_cnt <= 0;
            cnt15 <= 0;
            bl_low_cnt <= 0;
        end else begin
            bl_low_cnt <= backlight_pulse_in ? 0 : (bl_low_cnt < 1000 ? bl_low_cnt + 1 : bl_low_cnt);
            ss_cnt <= soft_start_active ? ss_cnt + 1 : 0;
            // saturate: only the threshold crossing matters
            low_cnt <= (backlight_pulse_in || flash_pulse_in) ? 0 : (low_cnt < 1000 ? low_cnt + 1 : low_cnt);
            cnt15 <= (pump_gain == GAIN_15X) ? cnt15 + 1 : 0;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    chk_bl_range: assert property (backlight_percent != 7'h00 |->
        ((backlight_percent % 10 == 0) && backlight_percent <= 7'h64) || backlight_percent == 7'h05)
        else $error("backlight level outside the eleven steps");
    chk_bl_step: assert property (($past(backlight_percent) != 7'h00 && backlight_percent != 7'h00 &&
        $changed(backlight_percent)) |-> (backlight_percent == $past(backlight_percent) - 7'h0a ||
        ($past(backlight_percent) == 7'h0a && backlight_percent == 7'h05) ||
        ($past(backlight_percent) == 7'h05 && backlight_percent == 7'h64)))
        else $error("backlight level moved by a wrong step");
    chk_fl_step: assert property (($past(flash_current_ma) != 7'h00 && flash_current_ma != 7'h00 &&
        $changed(flash_current_ma)) |-> (flash_current_ma == $past(flash_current_ma) - 7'h0a ||
        ($past(flash_current_ma) == 7'h0a && flash_current_ma == 7'h05) ||
        ($past(flash_current_ma) == 7'h05 && flash_current_ma == 7'h64)))
        else $error("flash current moved by a wrong step");
    chk_ss_length: assert property ($fell(soft_start_active) |->
        ss_cnt inside {[SS_CYCLES - 2 : SS_CYCLES + 2]})
        else $error("soft-start length wrong");
    chk_idle_shutdown: assert property ((low_cnt > SHDN_CYCLES + 8) |-> shutdown)
        else $error("both inputs long low without shutdown");
    chk_no_gain_skip: assert property ($past(pump_gain) == GAIN_1X |-> pump_gain != GAIN_2X)
        else $error("gain jumped from 1x to 2x");
    chk_dwell_2x: assert property ($rose(pump_gain == GAIN_2X) |-> cnt15 >= DWELL_CYCLES - 1)
        else $error("2x entered without dwell in 1.5x");
    chk_headroom_up: assert property ((pump_enable && pump_gain == GAIN_1X &&
        (headroom_low & led_enable) != 6'h00)[*4] |-> ##[0:4] pump_gain == GAIN_15X)
        else $error("low headroom did not raise gain");
    chk_split_revert: assert property ((bl_low_cnt == SHDN_CYCLES + 2 && flash_pulse_in &&
        $past(flash_pulse_in, 4) && pump_gain == GAIN_2X) |-> ##[1:4] pump_gain == GAIN_15X)
        else $error("gain stayed 2x after the backlight group was released");
    chk_led_disable: assert property ((led_pin_high[0])[*6] |-> !led_enable[0])
        else $error("channel enabled with pin too high");
    chk_short_stop: assert property (pump_output_voltage_short[*6] |-> !pump_enable && led_enable == 6'h00)
        else $error("pump or channels running during short");
    chk_hot_shutdown: assert property (over_temp[*6] |-> shutdown && !pump_enable)
        else $error("device running while over temperature");
endmodule

bind lpd_ctrl lpd_ctrl_chk #(.SHDN_CYCLES(SHDN_CYCLES), .SS_CYCLES(SS_CYCLES), .DWELL_CYCLES(DWELL_CYCLES)) chk_u (
    .clock(clock), .rstn(rstn), .backlight_pulse_in(backlight_pulse_in), .flash_pulse_in(flash_pulse_in),
    .headroom_low(headroom_low), .led_pin_high(led_pin_high), .pump_output_voltage_short(pump_output_voltage_short), .over_temp(over_temp),
    .led_enable(led_enable), .backlight_percent(backlight_percent), .flash_current_ma(flash_current_ma),
    .pump_gain(pump_gain), .pump_enable(pump_enable), .soft_start_active(soft_start_active), .shutdown(shutdown)
);

/* tb/lpd_host.sv */
// host gpio model driving the two pulse-coded enable pins
`timescale 1ns/1ps
module lpd_host #(
    parameter int LOW_CYC = 4,
    parameter int HIGH_CYC = 6,
    parameter int INIT_CYC = 12,
    parameter int LONG_CYC = 40
) (
    input wire logic clock,
    output logic backlight_pulse_in,
    output logic flash_pulse_in
);
    logic [1:0] pin;
    assign backlight_pulse_in = pin[0];
    assign flash_pulse_in = pin[1];
    initial begin
        pin = 2'b00;
    end

    // first high after shutdown held before any pulse; pulses follow soon after
    task rise(input int ch);
        pin[ch] <= 1'b1;
        repeat (INIT_CYC) @(posedge clock);
    endtask

    // low phase kept far below the shutdown delay so it never reads as a reset
    task pulse(input int ch);
        pin[ch] <= 1'b0;
        repeat (LOW_CYC) @(posedge clock);
        pin[ch] <= 1'b1;
        repeat (HIGH_CYC) @(posedge clock);
    endtask

    // long low, the way back to an absolute level
    task lower(input int ch);
        pin[ch] <= 1'b0;
        repeat (LONG_CYC) @(posedge clock);
    endtask
endmodule

/* tb/led_pulse_dimming_and_pump_mode_ctrl_tb.sv */
// self-checking bench: pulse dimming, gain sequencing, faults and register access
`timescale 1ns/1ps
module led_pulse_dimming_and_pump_mode_ctrl_tb
    import lpd_pkg::*;
;
    // shortened counts keep the run small
    localparam int SHDN = 20;
    localparam int SS = 30;
    localparam int DWELL = 10;
    localparam int RETRY = 100;
    logic clock = 1'b0;
    logic rstn, backlight_pulse_in, flash_pulse_in, dropout_det, pump_output_voltage_le_vin, pump_output_voltage_short, over_temp;
    logic psel, penable, pwrite, pready, pslverr, err, pump_enable, soft_start_active, shutdown;
    logic [5:0] headroom_low, led_pin_high, led_enable;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0] backlight_percent, flash_current_ma;
    logic [2:0] pump_gain;
    int bad_count = 0;
    int total_checks = 0;
    int idx [2];

    always #5 clock = ~clock;

    lpd_ctrl #(.SHDN_CYCLES(SHDN), .SS_CYCLES(SS), .DWELL_CYCLES(DWELL), .RETRY_CYCLES(RETRY)) dut_u (
        .clock(clock), .rstn(rstn), .backlight_pulse_in(backlight_pulse_in), .flash_pulse_in(flash_pulse_in),
        .headroom_low(headroom_low), .led_pin_high(led_pin_high), .dropout_det(dropout_det),
        .pump_output_voltage_le_vin(pump_output_voltage_le_vin), .pump_output_voltage_short(pump_output_voltage_short), .over_temp(over_temp), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .led_enable(led_enable), .backlight_percent(backlight_percent),
        .flash_current_ma(flash_current_ma), .pump_gain(pump_gain), .pump_enable(pump_enable),
        .soft_start_active(soft_start_active), .shutdown(shutdown)
    );

    lpd_host #(.LONG_CYC(SHDN + 20)) host_u (
        .clock(clock), .backlight_pulse_in(backlight_pulse_in), .flash_pulse_in(flash_pulse_in)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic results();
        if (bad_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    function automatic logic [6:0] lvl(input int k);
        return (k == 10) ? 7'h05 : 7'(100 - 10 * k);
    endfunction

    // comparator side: 0 headroom, 1 pin high, 2 dropout, 3 out not above in, 4 short, 5 hot
    task automatic drive(input int sel, input logic [5:0] v);
        case (sel)
            0: headroom_low <= v;
            1: led_pin_high <= v;
            2: dropout_det <= v[0];
            3: pump_output_voltage_le_vin <= v[0];
            4: pump_output_voltage_short <= v[0];
            default: over_temp <= v[0];
        endcase
    endtask

    function automatic bit cnd(input int s);
        case (s)
            0: return shutdown === 1'b1;
            1: return pump_gain === GAIN_15X;
            2: return pump_gain === GAIN_2X;
            3: return pump_gain === GAIN_1X;
            4: return backlight_percent !== 7'h00;
            default: return shutdown === 1'b0 && soft_start_active === 1'b0;
        endcase
    endfunction

    task automatic wait_cond(input int s, input int lim);
        int n;
        n = 0;
        total_checks++;
        while (!cnd(s) && n < lim) begin
            @(posedge clock);
            n++;
        end
        if (!cnd(s)) begin
            bad_count++;
            $display("wrong value at %0t: condition %0d never reached", $time, s);
            results();
        end
    endtask

    // called just after a rising edge; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            bad_count++;
            $display("wrong value at %0t: bus answer missing", $time);
            results();
        end
        // one idle edge, so a following setup never reassigns psel in the same step
        @(posedge clock);
    endtask

    task automatic step(input int ch);
        host_u.pulse(ch);
        idx[ch] = (idx[ch] == 10) ? 0 : idx[ch] + 1;
        repeat (8) @(posedge clock);
        chk(ch ? flash_current_ma : backlight_percent, lvl(idx[ch]));
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rstn = 1'b0;
        {headroom_low, led_pin_high, dropout_det, pump_output_voltage_le_vin, pump_output_voltage_short, over_temp} = '0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        repeat (6) @(posedge clock);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, CTRL_RST);
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        host_u.rise(0);
        wait_cond(4, SS + 60);
        chk({led_enable[3:0], backlight_percent}, {4'hf, 7'h64});
        idx = '{0, 0};
        for (int k = 0; k < 10; k++) begin
            step(0);
        end
        apb(1'b0, 12'h008, 32'h0);
        chk(rd[6:0], 7'h05);
        step(0);
        host_u.rise(1);
        repeat (8) @(posedge clock);
        chk(flash_current_ma, 7'h64);
        for (int k = 0; k < 14; k++) begin
            step(1);
        end
        host_u.lower(1);
        chk(led_enable[5:4], 2'b00);
        host_u.rise(1);
        repeat (8) @(posedge clock);
        chk(flash_current_ma, 7'h64);
        idx[1] = 0;
        drive(0, 6'h0f);
        wait_cond(1, 40);
        drive(2, 6'h01);
        wait_cond(2, DWELL + 40);
        host_u.lower(0);
        chk({shutdown, backlight_percent}, 8'h00);
        drive(2, 6'h00);
        drive(0, 6'h00);
        drive(3, 6'h01);
        wait_cond(3, 2 * RETRY + 80);
        drive(3, 6'h00);
        host_u.rise(0);
        wait_cond(4, 40);
        chk(backlight_percent, 7'h64);
        idx[0] = 0;
        for (int k = 0; k < 7; k++) begin
            step(0);
        end
        drive(0, 6'h0f);
        wait_cond(1, 40);
        drive(2, 6'h01);
        wait_cond(2, DWELL + 40);
        wait_cond(1, RETRY + 40);
        drive(2, 6'h00);
        drive(0, 6'h00);
        drive(3, 6'h01);
        wait_cond(3, RETRY + 60);
        drive(3, 6'h00);
        drive(1, 6'h01);
        repeat (8) @(posedge clock);
        chk(led_enable, 6'h3e);
        drive(1, 6'h00);
        drive(4, 6'h01);
        repeat (8) @(posedge clock);
        chk({pump_enable, led_enable}, 7'h00);
        drive(4, 6'h00);
        repeat (8) @(posedge clock);
        chk({pump_enable, led_enable, backlight_percent}, {1'b1, 6'h3f, 7'h1e});
        drive(5, 6'h01);
        repeat (8) @(posedge clock);
        chk(shutdown, 1'b1);
        drive(5, 6'h00);
        wait_cond(5, SS + 60);
        chk(backlight_percent, 7'h1e);
        host_u.lower(0);
        host_u.lower(1);
        wait_cond(0, 20);
        host_u.rise(0);
        wait_cond(5, SS + 60);
        apb(1'b1, 12'h000, 32'h0);
        wait_cond(0, 20);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h000, 32'hffff_ffff);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0000_0001);
        wait_cond(5, SS + 60);
        results();
    end
endmodule
